// file: gdf_channel.sv
// One driver channel: gate command, fault tracking and clear sequencing
`timescale 1ns/1ps
module gdf_channel (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic pwm_in,
  input wire logic fault_n_sync_in,
  input wire logic bus_fault_in,
  input wire logic global_mode_in,
  input wire logic clear_req_in,
  output logic noninv_control_out,
  output logic inv_control_out,
  output logic clear_n_out,
  output logic fault_out
);
  typedef enum logic [1:0] {RUN, FAULTED, SETUP, CLEARING} gdf_state_e;
  gdf_state_e state_r, state_nxt;
  logic [gdf_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic fault_r, fault_nxt;
  logic gate_r, gate_nxt;
  logic clr_n_r, clr_n_nxt;
  logic fault_seen;

  always_comb begin
    fault_seen = ~fault_n_sync_in | (global_mode_in & bus_fault_in);
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    fault_nxt = fault_r;
    gate_nxt = gate_r;
    clr_n_nxt = 1'b1;
    case (state_r)
      RUN: begin
        gate_nxt = pwm_in;
        if (fault_seen) begin
          state_nxt = FAULTED;
          fault_nxt = 1'b1;
          gate_nxt = 1'b0;
        end
      end
      FAULTED: begin
        gate_nxt = 1'b0;
        cnt_nxt = '0;
        if (clear_req_in) begin
          state_nxt = SETUP;
        end
      end
      SETUP: begin
        // Gate-low must be settled at the driver before clear goes low
        gate_nxt = 1'b0;
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == gdf_pkg::CNT_W'(gdf_pkg::CLEAR_SETUP_CYC - 1)) begin
          state_nxt = CLEARING;
          cnt_nxt = '0;
          // Clear falls on entry so the pulse spans all CLEAR_PULSE_CYC cycles
          clr_n_nxt = 1'b0;
        end
      end
      default: begin
        gate_nxt = 1'b0;
        clr_n_nxt = 1'b0;
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == gdf_pkg::CNT_W'(gdf_pkg::CLEAR_PULSE_CYC - 1)) begin
          clr_n_nxt = 1'b1;
          cnt_nxt = '0;
          // A fault still present wins over the clear
          if (fault_seen) begin
            state_nxt = FAULTED;
          end else begin
            state_nxt = RUN;
            fault_nxt = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_r <= RUN;
      cnt_r <= '0;
      fault_r <= 1'b0;
      gate_r <= 1'b0;
      clr_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      fault_r <= fault_nxt;
      gate_r <= gate_nxt;
      clr_n_r <= clr_n_nxt;
    end
  end

  assign noninv_control_out = gate_r;
  assign inv_control_out = 1'b0;
  assign clear_n_out = clr_n_r;
  assign fault_out = fault_r;
endmodule // gdf_channel

// file: gdf_checker.sv
// Port checker for the fault supervisor
`timescale 1ns/1ps
module gdf_checker (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic global_mode_in,
  input wire logic [5:0] fault_n_in,
  input wire logic [5:0] noninv_control_out,
  input wire logic [5:0] clear_n_out,
  input wire logic [5:0] fault_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  property p_off; (noninv_control_out & fault_out) == 0; endproperty
  a_off: assert property (p_off) else $error("gate on in fault");
  property p_clr; (noninv_control_out & ~clear_n_out) == 0; endproperty
  a_clr: assert property (p_clr) else $error("clear with gate on");
  property p_set; $fell(fault_n_in[0]) |-> ##[1:5] fault_out[0]; endproperty
  a_set: assert property (p_set) else $error("fault not latched");
  property p_bus; global_mode_in && $fell(fault_n_in[0]) |-> ##[1:6] &fault_out; endproperty
  a_bus: assert property (p_bus) else $error("bus fault not shared");
  property p_own; $rose(fault_out[1]) && !global_mode_in |-> !$past(fault_n_in[1], 3); endproperty
  a_own: assert property (p_own) else $error("foreign fault");
  property p_len; $fell(clear_n_out[0]) |-> ##124 !clear_n_out[0] ##1 clear_n_out[0]; endproperty
  a_len: assert property (p_len) else $error("clear pulse length");
  property p_req; $fell(clear_n_out[0]) |-> fault_out[0]; endproperty
  a_req: assert property (p_req) else $error("clear without fault");
  property p_hold; $fell(fault_out[0]) |-> !$past(clear_n_out[0]) || !$past(clear_n_out[0], 2); endproperty
  a_hold: assert property (p_hold) else $error("fault dropped early");
  c_clr: cover property ($fell(clear_n_out[0]));
  c_bus: cover property (global_mode_in && &fault_out);
  c_own: cover property ($rose(fault_out[1]));
endmodule // gdf_checker
bind gdf_supervisor gdf_checker chk_u (.clock_in, .rst_n_in, .global_mode_in, .fault_n_in,
  .noninv_control_out, .clear_n_out, .fault_out);

// file: gdf_drv_model.sv
// Model of six gate drivers with set-dominant fault latches
`timescale 1ns/1ps
module gdf_drv_model (
  input wire logic [5:0] gate_in,
  input wire logic [5:0] clear_n_in,
  input wire logic [5:0] sense_in,
  output logic [5:0] fault_n_out = 6'h3f
);
  // Clear is honoured only with the gate commanded low, as in auto-reset use
  always @* fault_n_out = ~sense_in & (fault_n_out | ~clear_n_in & ~gate_in);
endmodule // gdf_drv_model

// file: gdf_pkg.sv
// Package of constants for the gate driver fault supervisor
// Notes on behaviour
// - Poll each driver fault line separately
// - Clear each driver with its own line
// - Put inputs gate-low before pulling clear low
// - Clear pulse from controller or sync gate
package gdf_pkg;
  localparam int unsigned NUM_DRV = 6;
  localparam int unsigned CLK_MHZ = 125;
  // Hold times in nanoseconds
  localparam int unsigned CLEAR_SETUP_NS = 1000;
  localparam int unsigned CLEAR_PULSE_NS = 1000;
  localparam int unsigned CLEAR_SETUP_CYC = (CLEAR_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CLEAR_PULSE_CYC = (CLEAR_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 8;
endpackage

// file: gdf_supervisor.sv
// Top: supervises six gate drivers, local or shared-bus fault handling
`timescale 1ns/1ps
module gdf_supervisor (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic global_mode_in,
  input wire logic [gdf_pkg::NUM_DRV-1:0] pwm_in,
  input wire logic [gdf_pkg::NUM_DRV-1:0] clear_req_in,
  input wire logic [gdf_pkg::NUM_DRV-1:0] fault_n_in,
  output logic [gdf_pkg::NUM_DRV-1:0] noninv_control_out,
  output logic [gdf_pkg::NUM_DRV-1:0] inv_control_out,
  output logic [gdf_pkg::NUM_DRV-1:0] clear_n_out,
  output logic [gdf_pkg::NUM_DRV-1:0] fault_out,
  output logic any_fault_out
);
  logic [gdf_pkg::NUM_DRV-1:0] meta_r, meta_nxt;
  logic [gdf_pkg::NUM_DRV-1:0] sync_r, sync_nxt;
  logic bus_r, bus_nxt;
  logic any_r, any_nxt;

  // Fault pins are asynchronous to this clock
  always_comb begin
    meta_nxt = fault_n_in;
    sync_nxt = meta_r;
    // Wired fault bus: in global mode, any low line faults every driver
    bus_nxt = ~&sync_r;
    any_nxt = |fault_out;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      meta_r <= '1;
      sync_r <= '1;
      bus_r <= 1'b0;
      any_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      bus_r <= bus_nxt;
      any_r <= any_nxt;
    end
  end

  assign any_fault_out = any_r;

  genvar g;
  generate
    for (g = 0; g < gdf_pkg::NUM_DRV; g++) begin : g_ch
      gdf_channel u_ch (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .pwm_in(pwm_in[g]),
        .fault_n_sync_in(sync_r[g]),
        .bus_fault_in(bus_r),
        .global_mode_in(global_mode_in),
        .clear_req_in(clear_req_in[g]),
        .noninv_control_out(noninv_control_out[g]),
        .inv_control_out(inv_control_out[g]),
        .clear_n_out(clear_n_out[g]),
        .fault_out(fault_out[g])
      );
    end
  endgenerate
endmodule // gdf_supervisor

// file: tb_gdf_supervisor.sv
// Bench for the fault supervisor against six driver models
`timescale 1ns/1ps
module tb_gdf_supervisor;
  logic clock_in = 0, rst_n_in = 0, global_mode_in = 0;
  logic [5:0] pwm_in = 6'h3f, clear_req_in = 0, sense = 0, fault_n, gate, clear_n, fault, inv;
  logic any_f;
  int n_fail = 0, n_compared = 0, cyc = 0;
  logic [12:0] rows [3] = '{13'h107f, 13'h0041, 13'h0492};
  always #4 clock_in = ~clock_in;
  always @(posedge clock_in) if (++cyc > 4000) wrap_up();
  gdf_supervisor dut_u (.clock_in, .rst_n_in, .global_mode_in, .pwm_in, .clear_req_in,
    .fault_n_in(fault_n), .noninv_control_out(gate), .inv_control_out(inv),
    .clear_n_out(clear_n), .fault_out(fault), .any_fault_out(any_f));
  gdf_drv_model drv_u (.gate_in(gate), .clear_n_in(clear_n), .sense_in(sense), .fault_n_out(fault_n));
  task chk(string nm, logic [5:0] e, g);
    {n_compared, n_fail} = {n_compared + 1, n_fail + (g !== e)};
    if (g !== e) $display("MISMATCH %s expected %h seen %h", nm, e, g);
  endtask
  task wrap_up;
    n_fail += int'(cyc > 4000);
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Reset is released at the end of the first wait and stays released
  task clr(logic [5:0] r, int n);
    clear_req_in = r;
    @(negedge clock_in) clear_req_in = 0;
    repeat (n) @(negedge clock_in);
    rst_n_in = 1;
  endtask
  initial begin
    clr(0, 10);
    foreach (rows[r]) begin
      {global_mode_in, sense} = rows[r][12:6];
      clr(0, 8);
      sense = 0;
      chk("fault", rows[r][5:0], fault);
      chk("any", 6'h01, {5'h00, any_f});
      chk("inv", 6'h00, inv);
      clr(rows[r][5:0], 300);
      chk("cleared", 0, fault);
    end
    // Fault held through the clear pulse, with pwm held at 0b throughout
    {pwm_in, sense} = 12'h2e4;
    clr(0, 8);
    clr(6'h3f, 300);
    chk("kept", 6'h24, fault);
    chk("gate", 6'h0b, gate);
    wrap_up();
  end
endmodule // tb_gdf_supervisor
